// [ssm_host.sv]
`timescale 1ns/1ps
module ssm_host (
   // Clock
   input  wire logic clk_i,
   // Device output
   input  wire logic so_i,
   input  wire logic so_oe_n_i,
   // Host pins
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      si_o,
   output logic      hold_n_o,
   output logic      wp_n_o
);
   logic last_so_ff;
   logic so_w;
   logic held_oe_n;
   initial begin
      sck_o = 0;
      cs_n_o = 1;
      si_o = 0;
      hold_n_o = 1;
      wp_n_o = 1;
      held_oe_n = 0;
      last_so_ff = 0;
   end
   // Released line shows the inverse of its last driven level
   always @(posedge clk_i) begin
      if (!so_oe_n_i) last_so_ff <= so_i;
   end
   assign so_w = so_oe_n_i ? ~last_so_ff : so_i;
   // Half of a 64 ns serial clock
   task automatic half();
      repeat (4) @(negedge clk_i);
   endtask
   // Idle level picks the mode; whole bytes only; hold moves while selected
   task automatic frame(input logic m3, input logic [7:0] tx[$], output logic [7:0] rx[$],
                        input int hold_at);
      logic [7:0] b;
      rx = {};
      sck_o = m3;
      half();
      cs_n_o = 0;
      half();
      foreach (tx[k]) begin
         if (k == hold_at) begin
            hold_n_o = 0;
            half();
            held_oe_n = so_oe_n_i;
            sck_o = ~sck_o;
            half();
            sck_o = ~sck_o;
            half();
            hold_n_o = 1;
            half();
         end
         for (int i = 7; i >= 0; i--) begin
            sck_o = 0;
            si_o = tx[k][i];
            half();
            sck_o = 1;
            half();
            b[i] = so_w;
         end
         rx.push_back(b);
      end
      if (!m3) sck_o = 0;
      half();
      cs_n_o = 1;
      si_o = ~si_o;
      half();
      half();
   endtask
endmodule

// [ssm_if.sv]
`timescale 1ns/1ps
interface ssm_if;
   logic sck_s;
   logic cs_n_s;
   logic si_s;
   logic hold_n_s;
   logic wp_n_s;
   modport sync (output sck_s, cs_n_s, si_s, hold_n_s, wp_n_s);
   modport core (input  sck_s, cs_n_s, si_s, hold_n_s, wp_n_s);
endinterface

// [ssm_pkg.sv]
package ssm_pkg;
   localparam logic [7:0] CMD_SET_WEL  = 8'h06;
   localparam logic [7:0] CMD_CLR_WEL  = 8'h04;
   localparam logic [7:0] CMD_STAT_RD  = 8'h05;
   localparam logic [7:0] CMD_STAT_WR  = 8'h01;
   localparam logic [7:0] CMD_DATA_RD  = 8'h03;
   localparam logic [7:0] CMD_DATA_WR  = 8'h02;
   localparam logic [7:0] CMD_SLEEP    = 8'hB9;
   localparam logic [7:0] CMD_WAKE     = 8'hAB;
   localparam int         SR_SWD_POS   = 7;
   localparam int         SR_BPH_POS   = 3;
   localparam int         SR_BPL_POS   = 2;
   localparam int         SR_WEL_POS   = 1;
   localparam logic [7:0] SR_RESET     = 8'h00;
   localparam int         ADDR_BYTES   = 2;
   localparam int         CLK_MHZ      = 125;
   localparam int         SCK_MAX_MHZ  = 40;
   typedef enum logic [2:0] {
      SSM_CMD, SSM_ADDR, SSM_RDATA, SSM_WDATA, SSM_SRD, SSM_SWR, SSM_DONE
   } ssm_state_t;
endpackage

// [ssm_port.sv]
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Chip select low active; high ignores, tristates
// RQ2 - Output driven only returning read data
// RQ3 - Output tristated while suspend low
// RQ4 - Write-protect low blocks status writes; code blocks them only while status bit 7 (SWD) is set
// RQ5 - Serial input sampled on rising edges
// RQ6 - Output changes only on falling edges
// RQ7 - Mode 0/3 from clock at select
// RQ8 - Up to 40 MHz, static operation
// RQ9 - Suspend freezes operation, ignores select/clock
// RQ10 - Host changes suspend only while selected
// RQ11 - Command byte, address, then data
// RQ12 - One command per select period
// RQ13 - Host ends access on byte boundary
// RQ14 - 06h sets, 04h clears write latch
// RQ15 - 05h returns status byte
// RQ16 - 01h writes one status byte
// RQ17 - 03h two address bytes, streaming read
// RQ18 - 02h two address bytes, streaming write
// RQ19 - B9h enters sleep
// RQ20 - ABh exits sleep
// RQ21 - Fifteen address bits, wrap at top
// RQ22 - Status bits 7, 3, 2, 1 meaningful; code also stores written bits 6 to 4 and 0
// RQ23 - Latch clear refuses writes; resets zero
// RQ24 - Sleeping accepts only wake
// RQ25 - Select rise aborts command, resets counter
// RQ26 - Unknown command ignored, output tristate
module ssm_port
   import ssm_pkg::*;
#(
   parameter int ADDR_W = 15
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // Serial pins
   input  wire logic              sck_i,
   input  wire logic              cs_n_i,
   input  wire logic              si_i,
   input  wire logic              hold_n_i,
   input  wire logic              wp_n_i,
   output logic                   so_o,
   output logic                   so_oe_n_o,
   // State view
   output logic [7:0]             status_o,
   output logic                   sleep_o,
   output logic                   mode3_o
);
   import ssm_pkg::*;
   localparam int DEPTH = 1 << ADDR_W;
   // Address logic needs a high byte and two block-protect bits
   if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_width
      $error("ADDR_W out of range");
   end
   if (CLK_MHZ < 3 * SCK_MAX_MHZ) begin : g_slow_clk
      $error("clock too slow for link"); // [RQ8]
   end

   ssm_if pins ();
   ssm_sync u_sync (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n_i),
      .sck_i    (sck_i),
      .cs_n_i   (cs_n_i),
      .si_i     (si_i),
      .hold_n_i (hold_n_i),
      .wp_n_i   (wp_n_i),
      .pins     (pins)
   );

   logic [7:0]  mem [DEPTH];
   logic        sck_d_ff;
   logic        cs_d_ff;
   logic        act_ff;
   ssm_state_t  state_ff;
   logic [2:0]  bit_ff;
   logic [7:0]  sh_ff;
   logic [0:0]  abyte_ff;
   logic [15:0] addr_ff;
   logic [7:0]  tx_ff;
   logic        so_ff;
   logic        oe_ff;
   logic [7:0]  sr_ff;
   logic        sleep_ff;
   logic        mode3_ff;
   logic        run;
   logic        rise;
   logic        fall;
   logic        cs_fall;
   logic        cs_rise;
   logic [7:0]  nxt_byte;
   logic [15:0] nxt_addr;
   logic        byte_done;

   // Suspend freezes every edge detector and ignores select and clock
   assign run       = pins.hold_n_s; // [RQ9]
   assign rise      = run && act_ff && pins.sck_s && !sck_d_ff;
   assign fall      = run && act_ff && !pins.sck_s && sck_d_ff;
   assign cs_fall   = run && cs_d_ff && !pins.cs_n_s;
   assign cs_rise   = run && !cs_d_ff && pins.cs_n_s;
   assign nxt_byte  = {sh_ff[6:0], pins.si_s};
   assign byte_done = rise && (bit_ff == 3'd7);
   assign nxt_addr  = addr_inc(addr_ff);

   function automatic logic [15:0] addr_inc(input logic [15:0] a);
      logic [ADDR_W-1:0] low;
      low = a[ADDR_W-1:0] + 1'b1;
      return {{(16 - ADDR_W){1'b0}}, low}; // [RQ21]
   endfunction

   function automatic logic wr_protected(input logic [15:0] a, input logic [7:0] sr);
      logic [1:0] bp;
      logic [1:0] top;
      bp  = {sr[SR_BPH_POS], sr[SR_BPL_POS]};
      top = a[ADDR_W-1 -: 2];
      unique case (bp)
         2'd0: return 1'b0;
         2'd1: return top == 2'd3;
         2'd2: return top[1];
         2'd3: return 1'b1;
      endcase
   endfunction

   // Edge history; frozen while suspended
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sck_d_ff <= 1'b0;
         cs_d_ff  <= 1'b1;
      end else if (run) begin
         sck_d_ff <= pins.sck_s;
         cs_d_ff  <= pins.cs_n_s;
      end
   end

   // Selected window and clock mode
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         act_ff   <= 1'b0;
         mode3_ff <= 1'b0;
      end else if (cs_fall) begin
         act_ff   <= 1'b1; // [RQ1] [RQ11]
         mode3_ff <= pins.sck_s; // [RQ7]
      end else if (cs_rise) begin
         act_ff   <= 1'b0; // [RQ1]
      end
   end

   // Bit counter and shift register, sampling on rising edges
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || cs_fall || cs_rise) begin
         bit_ff <= 3'd0; // [RQ25]
         sh_ff  <= 8'h00;
      end else if (rise) begin
         bit_ff <= bit_ff + 3'd1; // [RQ5]
         sh_ff  <= nxt_byte;
      end
   end

   // Command sequencer
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || cs_fall || cs_rise) begin
         state_ff <= SSM_CMD; // [RQ25] [RQ12]
         abyte_ff <= 1'b0;
      end else if (byte_done) begin
         unique case (state_ff)
            SSM_CMD: begin
               if (sleep_ff) begin
                  state_ff <= SSM_DONE; // [RQ24]
               end else begin
                  unique case (nxt_byte)
                     CMD_DATA_RD, CMD_DATA_WR: state_ff <= SSM_ADDR; // [RQ17] [RQ18]
                     CMD_STAT_RD: state_ff <= SSM_SRD; // [RQ15]
                     CMD_STAT_WR: state_ff <= SSM_SWR; // [RQ16]
                     default:     state_ff <= SSM_DONE; // [RQ26] [RQ14]
                  endcase
               end
            end
            SSM_ADDR: begin
               abyte_ff <= abyte_ff + 1'b1;
               if (abyte_ff == 1'(ADDR_BYTES - 1)) begin
                  state_ff <= (tx_ff == CMD_DATA_RD) ? SSM_RDATA : SSM_WDATA;
               end
            end
            SSM_SRD:   state_ff <= SSM_DONE;
            SSM_SWR:   state_ff <= SSM_DONE; // [RQ16]
            SSM_RDATA: state_ff <= SSM_RDATA;
            SSM_WDATA: state_ff <= SSM_WDATA;
            SSM_DONE:  state_ff <= SSM_DONE;
         endcase
      end
   end

   // Address register with wrap
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         addr_ff <= 16'h0000;
      end else if (byte_done && state_ff == SSM_ADDR) begin
         addr_ff <= {addr_ff[7:0], nxt_byte};
      end else if (byte_done && (state_ff == SSM_RDATA || state_ff == SSM_WDATA)) begin
         addr_ff <= addr_inc(addr_ff); // [RQ21]
      end
   end

   // Memory writes, gated by latch and block protection
   always_ff @(posedge clk_i) begin
      if (byte_done && state_ff == SSM_WDATA && sr_ff[SR_WEL_POS] // [RQ23]
          && !wr_protected(addr_ff, sr_ff)) begin
         mem[addr_ff[ADDR_W-1:0]] <= nxt_byte; // [RQ18] [RQ21]
      end
   end

   // Status register, latch and sleep
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sr_ff    <= SR_RESET; // [RQ23]
         sleep_ff <= 1'b0;
      end else if (byte_done && state_ff == SSM_CMD) begin
         if (nxt_byte == CMD_WAKE) begin
            sleep_ff <= 1'b0; // [RQ20]
         end else if (!sleep_ff) begin
            if (nxt_byte == CMD_SET_WEL) sr_ff[SR_WEL_POS] <= 1'b1; // [RQ14]
            if (nxt_byte == CMD_CLR_WEL) sr_ff[SR_WEL_POS] <= 1'b0; // [RQ14] [RQ23]
            if (nxt_byte == CMD_SLEEP)   sleep_ff <= 1'b1; // [RQ19]
         end
      end else if (byte_done && state_ff == SSM_SWR && sr_ff[SR_WEL_POS] // [RQ23]
                   && (!sr_ff[SR_SWD_POS] || pins.wp_n_s)) begin // [RQ4]
         sr_ff <= {nxt_byte[7:2], sr_ff[SR_WEL_POS], nxt_byte[0]}; // [RQ22]
      end
   end

   // Transmit byte: loads on byte boundaries, shifts on falling edges
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         tx_ff <= 8'h00;
      end else if (byte_done && state_ff == SSM_CMD) begin
         if (nxt_byte == CMD_STAT_RD) tx_ff <= sr_ff; // [RQ15]
         else tx_ff <= nxt_byte;
      end else if (byte_done && state_ff == SSM_ADDR && abyte_ff == 1'b1) begin
         tx_ff <= mem[{addr_ff[ADDR_W-9:0], nxt_byte}]; // [RQ17]
      end else if (byte_done && state_ff == SSM_RDATA) begin
         tx_ff <= mem[nxt_addr[ADDR_W-1:0]]; // [RQ17] [RQ21]
      end else if (fall && oe_ff && bit_ff != 3'd0) begin
         tx_ff <= {tx_ff[6:0], 1'b0};
      end
   end

   // Output drive: only in read phases, updated on falling edges
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || cs_rise) begin
         so_ff <= 1'b0;
         oe_ff <= 1'b0; // [RQ1] [RQ2]
      end else if (fall) begin
         oe_ff <= (state_ff == SSM_SRD || state_ff == SSM_RDATA); // [RQ2] [RQ26]
         so_ff <= (bit_ff == 3'd0) ? tx_ff[7] : tx_ff[6]; // [RQ6]
      end
   end

   // Enable low while driving
   assign so_o      = so_ff;
   assign so_oe_n_o = !(oe_ff && run && !pins.cs_n_s); // [RQ3] [RQ1]
   assign status_o  = sr_ff;
   assign sleep_o   = sleep_ff;
   assign mode3_o   = mode3_ff;

   a_idle_tristate: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ1]
      pins.cs_n_s |-> so_oe_n_o) else $error("output driven while deselected");
   a_hold_tristate: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ3]
      !pins.hold_n_s |-> so_oe_n_o) else $error("output driven during suspend");
   a_so_on_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ6]
      $changed(so_ff) |-> $past(fall || cs_rise)) else $error("output changed off falling edge");
   a_drive_read: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ2]
      !so_oe_n_o |-> (state_ff inside {SSM_SRD, SSM_RDATA, SSM_DONE}))
      else $error("output driven outside read");
   a_wp_blocks: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ4]
      (byte_done && state_ff == SSM_SWR && !pins.wp_n_s && sr_ff[SR_SWD_POS])
      |=> $stable(sr_ff)) else $error("status written while protected");
   a_wel_set: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ14]
      (byte_done && state_ff == SSM_CMD && nxt_byte == CMD_SET_WEL && !sleep_ff)
      |=> sr_ff[SR_WEL_POS]) else $error("latch not set");
   a_sleep_only_wake: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ24]
      (byte_done && state_ff == SSM_CMD && sleep_ff && nxt_byte != CMD_WAKE)
      |=> $stable(sr_ff) && sleep_ff ##1 state_ff == SSM_DONE)
      else $error("command accepted while asleep");
   a_rise_resets: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ25]
      cs_rise |=> (bit_ff == 3'd0 && state_ff == SSM_CMD)) else $error("abort failed");
   a_hold_freeze: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ9]
      !run |=> $stable(bit_ff) && $stable(state_ff)) else $error("moved during suspend");
   c_status_read: cover property (@(posedge clk_i) state_ff == SSM_SRD && fall);
   c_stream_read: cover property (@(posedge clk_i) byte_done && state_ff == SSM_RDATA);
   c_stream_write: cover property (@(posedge clk_i) byte_done && state_ff == SSM_WDATA);
   c_mode3: cover property (@(posedge clk_i) cs_fall && pins.sck_s);
endmodule

// [ssm_port_test.sv]
`timescale 1ns/1ps
module ssm_port_test;
   import ssm_pkg::*;
   logic       clk_i = 0;
   logic       rst_n_i = 0;
   logic       sck, cs_n, si, hold_n, wp_n, so, so_oe_n, sleep, mode3;
   logic [7:0] status;
   logic [7:0] rx[$];
   logic       drv_ff = 0;
   int         miscompares = 0;
   int         num_checks = 0;
   int         cycles = 0;
   always #4 clk_i = ~clk_i;
   ssm_host host (.clk_i(clk_i), .so_i(so), .so_oe_n_i(so_oe_n), .sck_o(sck), .cs_n_o(cs_n),
                  .si_o(si), .hold_n_o(hold_n), .wp_n_o(wp_n));
   ssm_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
                 .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so), .so_oe_n_o(so_oe_n),
                 .status_o(status), .sleep_o(sleep), .mode3_o(mode3));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (!so_oe_n) drv_ff <= 1;
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic go(input logic m3, input logic [7:0] tx[$]);
      drv_ff = 0;
      host.frame(m3, tx, rx, -1);
   endtask
   initial begin
      repeat (16) @(negedge clk_i);
      rst_n_i = 1;
      repeat (4) @(negedge clk_i);
      chk(status, SR_RESET);
      chk(sleep, 0);
      chk(so_oe_n, 1);
      $display("reset test done");
      go(1, '{CMD_STAT_RD, 8'h00});
      chk(rx[1], 8'h00);
      chk(mode3, 1);
      chk(drv_ff, 1);
      chk(so_oe_n, 1);
      go(0, '{CMD_SET_WEL});
      chk(status[SR_WEL_POS], 1);
      chk(mode3, 0);
      go(0, '{CMD_DATA_WR, 8'h7F, 8'hFE, 8'h11, 8'h22, 8'h33});
      chk(drv_ff, 0);
      go(0, '{CMD_DATA_RD, 8'hFF, 8'hFF, 8'h00, 8'h00});
      chk(rx[3], 8'h22);
      chk(rx[4], 8'h33);
      $display("stream test done");
      go(0, '{CMD_CLR_WEL});
      chk(status[SR_WEL_POS], 0);
      go(0, '{CMD_DATA_WR, 8'h00, 8'h00, 8'h5A});
      go(1, '{CMD_DATA_RD, 8'h00, 8'h00, 8'h00});
      chk(rx[3], 8'h33);
      go(0, '{CMD_SET_WEL});
      go(0, '{CMD_STAT_WR, 8'h8C});
      chk(status, 8'h8E);
      go(0, '{CMD_DATA_WR, 8'h00, 8'h00, 8'h5A});
      go(0, '{CMD_DATA_RD, 8'h00, 8'h00, 8'h00});
      chk(rx[3], 8'h33);
      host.wp_n_o = 0;
      go(0, '{CMD_STAT_WR, 8'h00});
      chk(status, 8'h8E);
      host.wp_n_o = 1;
      go(0, '{CMD_STAT_WR, 8'h00});
      chk(status, 8'h02);
      $display("protect test done");
      host.frame(0, '{CMD_DATA_RD, 8'h7F, 8'hFE, 8'h00, 8'h00, 8'h00}, rx, 4);
      chk(host.held_oe_n, 1);
      chk(rx[3], 8'h11);
      chk(rx[4], 8'h22);
      chk(rx[5], 8'h33);
      go(0, '{8'h5A, 8'h00});
      chk(drv_ff, 0);
      $display("hold test done");
      go(0, '{CMD_SLEEP});
      chk(sleep, 1);
      go(0, '{CMD_CLR_WEL});
      chk(status, 8'h02);
      go(0, '{CMD_STAT_RD, 8'h00});
      chk(drv_ff, 0);
      go(0, '{CMD_WAKE});
      chk(sleep, 0);
      go(0, '{CMD_CLR_WEL, CMD_SET_WEL});
      chk(status, 8'h00);
      $display("sleep test done");
      end_sim();
   end
endmodule

// [ssm_sync.sv]
`timescale 1ns/1ps
module ssm_sync (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Raw pins
   input  wire logic sck_i,
   input  wire logic cs_n_i,
   input  wire logic si_i,
   input  wire logic hold_n_i,
   input  wire logic wp_n_i,
   // Synchronised pins
   ssm_if.sync       pins
);
   logic [4:0] meta_ff;
   logic [4:0] sync_ff;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_ff <= 5'h1B;
         sync_ff <= 5'h1B;
      end else begin
         meta_ff <= {wp_n_i, hold_n_i, si_i, cs_n_i, sck_i};
         sync_ff <= meta_ff;
      end
   end
   assign pins.sck_s    = sync_ff[0];
   assign pins.cs_n_s   = sync_ff[1];
   assign pins.si_s     = sync_ff[2];
   assign pins.hold_n_s = sync_ff[3];
   assign pins.wp_n_s   = sync_ff[4];
endmodule
